// >>> rtl/egu_map.svh
// Register offsets, field positions and instance addresses of the event generator.
`ifndef EGU_MAP_SVH
`define EGU_MAP_SVH
`define EGU_NUM_TASKS       16
`define EGU_ADDR_W          12
`define EGU_OFS_TRIGGER     12'h000
`define EGU_OFS_SUBSCRIBE   12'h080
`define EGU_OFS_FLAG        12'h100
`define EGU_OFS_PUBLISH     12'h180
`define EGU_OFS_IRQ_EN      12'h300
`define EGU_OFS_IRQ_SET     12'h304
`define EGU_OFS_IRQ_CLR     12'h308
`define EGU_ARRAY_SPAN      12'h080
`define EGU_EN_BIT          31
`define EGU_CH_W            8
`define EGU_NUM_CH          256
`define EGU_IRQ_LATENCY     1
`define EGU_SEC_BASE        32'h5001B000
`define EGU_NSEC_BASE       32'h4001B000
`define EGU_INST_STRIDE     32'h00001000
`define EGU_NUM_INST        6
`endif

// >>> rtl/egu_pkg.sv
// Types shared by the event generator.
package egu_pkg;
	typedef struct packed {
		logic       enable;
		logic [7:0] channel_index;
	} egu_chan_cfg_t;

	typedef struct packed {
		logic        writeEn;
		logic        readEn;
		logic [11:0] addr;
		logic [31:0] wdata;
	} egu_bus_req_t;
endpackage

// >>> rtl/egu_event_generator.sv
// Event generator: sixteen trigger tasks, event flags, publish and interrupt.
//
// What this block does
// - Sixteen tasks; triggering task n sets only event flag n.
// - Writing 1 to trigger word n generates event n; writing 0 does nothing.
// - Tasks fire from CPU writes or from subscribed interconnect channels alike.
// - Each instance drives its own dedicated interrupt request line.
// - Subscribe word n holds channel index and enable bit 31 for task n.
// - Event flag word n reads 1 in bit 0 once event n was generated.
// - Publish word n with bit 31 set signals each event n on its channel.
// - Enable, set-enable and clear-enable words share one interrupt enable set.
// - Six instances, 4 KB apart, secure and non-secure aliases, via parameter.
// - Bit i gates event i; set and clear write ones only; reads return enables.
// - The interrupt rises on the same clock edge that sets an enabled flag.
//
// Added by the designer: strobed register access.
`timescale 1ns/100ps
`include "egu_map.svh"

module egu_event_generator
	import egu_pkg::*;
#(
	parameter int NUM_TASKS = `EGU_NUM_TASKS,
	parameter int INSTANCE  = 0
) (
	input  wire logic                        core_clk,     // Peripheral clock, 250 MHz.
	input  wire logic                        rstn,         // Asynchronous reset, active low.
	input  wire logic [`EGU_ADDR_W-1:0]      busAddr,      // Register byte address.
	input  wire logic [31:0]                 busWdata,     // Write data.
	input  wire logic                        busWrite,     // Write strobe.
	input  wire logic                        busRead,      // Read strobe.
	output logic      [31:0]                 busRdata,     // Read data, cycle after strobe.
	input  wire logic [`EGU_NUM_CH-1:0]      chanFire,     // Interconnect channel pulses.
	output logic      [`EGU_NUM_CH-1:0]      chanPublish,  // Published channel pulses.
	output logic                             irq           // Interrupt request level.
);

	localparam logic [31:0] SEC_ADDR  = `EGU_SEC_BASE + `EGU_INST_STRIDE * INSTANCE;
	localparam logic [31:0] NSEC_ADDR = `EGU_NSEC_BASE + `EGU_INST_STRIDE * INSTANCE;

	logic                 rstSync1;
	logic                 rstSyncN;
	logic [NUM_TASKS-1:0] flag_reg;
	logic [NUM_TASKS-1:0] flag_next;
	logic [NUM_TASKS-1:0] irqEn_reg;
	logic [NUM_TASKS-1:0] irqEn_next;
	egu_chan_cfg_t        sub_reg  [NUM_TASKS];
	egu_chan_cfg_t        sub_next [NUM_TASKS];
	egu_chan_cfg_t        pub_reg  [NUM_TASKS];
	egu_chan_cfg_t        pub_next [NUM_TASKS];
	logic [31:0]          rdata_next;
	logic [`EGU_NUM_CH-1:0] publish_next;
	logic                 irq_next;
	logic [NUM_TASKS-1:0] fireTask;
	logic [NUM_TASKS-1:0] flagSet;

	// Tells whether an address falls in a word array starting at base; wordIdx gives the index.
	function automatic logic inArray(input logic [11:0] a, input logic [11:0] base);
		inArray = (a >= base) && (a < base + `EGU_ARRAY_SPAN) && (a[1:0] == 2'h0)
			&& (a[6:2] < 5'(NUM_TASKS));
	endfunction

	function automatic int unsigned wordIdx(input logic [11:0] a);
		wordIdx = int'(a[6:2]);
	endfunction

	function automatic logic [31:0] cfgWord(input egu_chan_cfg_t c);
		cfgWord = {c.enable, 23'h000000, c.channel_index};
	endfunction

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			rstSync1 <= 1'b0;
			rstSyncN <= 1'b0;
		end else begin
			rstSync1 <= 1'b1;
			rstSyncN <= rstSync1;
		end
	end

	always_comb begin
		fireTask = '0;
		for (int n = 0; n < NUM_TASKS; n++) begin
			// Subscribed channel activity, with the enable in bit 31.
			if (sub_reg[n].enable && chanFire[sub_reg[n].channel_index])
				fireTask[n] = 1'b1;
			// Software trigger word; only a one in bit 0 fires the task.
			if (busWrite && inArray(busAddr, `EGU_OFS_TRIGGER)
				&& wordIdx(busAddr) == n && busWdata[0])
				fireTask[n] = 1'b1;
		end
	end

	assign flagSet = fireTask;

	always_comb begin
		flag_next  = flag_reg;
		irqEn_next = irqEn_reg;
		for (int n = 0; n < NUM_TASKS; n++) begin
			sub_next[n] = sub_reg[n];
			pub_next[n] = pub_reg[n];
		end
		if (busWrite) begin
			if (inArray(busAddr, `EGU_OFS_SUBSCRIBE)) begin
				sub_next[wordIdx(busAddr)].enable        = busWdata[`EGU_EN_BIT];
				sub_next[wordIdx(busAddr)].channel_index = busWdata[`EGU_CH_W-1:0];
			end
			if (inArray(busAddr, `EGU_OFS_PUBLISH)) begin
				pub_next[wordIdx(busAddr)].enable        = busWdata[`EGU_EN_BIT];
				pub_next[wordIdx(busAddr)].channel_index = busWdata[`EGU_CH_W-1:0];
			end
			if (inArray(busAddr, `EGU_OFS_FLAG))
				flag_next[wordIdx(busAddr)] = busWdata[0];
			case (busAddr)
				`EGU_OFS_IRQ_EN: irqEn_next = busWdata[NUM_TASKS-1:0];
				`EGU_OFS_IRQ_SET: irqEn_next = irqEn_reg | busWdata[NUM_TASKS-1:0];
				`EGU_OFS_IRQ_CLR: irqEn_next = irqEn_reg & ~busWdata[NUM_TASKS-1:0];
				default: irqEn_next = irqEn_next;
			endcase
		end
		// A new event wins over a software clear in the same cycle.
		flag_next = flag_next | flagSet;

		publish_next = '0;
		for (int n = 0; n < NUM_TASKS; n++) begin
			if (pub_reg[n].enable && flagSet[n])
				publish_next[pub_reg[n].channel_index] = 1'b1;
		end

		irq_next = |(flag_next & irqEn_next);

		rdata_next = 32'h00000000;
		if (busRead) begin
			if (inArray(busAddr, `EGU_OFS_SUBSCRIBE))
				rdata_next = cfgWord(sub_reg[wordIdx(busAddr)]);
			else if (inArray(busAddr, `EGU_OFS_PUBLISH))
				rdata_next = cfgWord(pub_reg[wordIdx(busAddr)]);
			else if (inArray(busAddr, `EGU_OFS_FLAG))
				rdata_next = {31'h00000000, flag_reg[wordIdx(busAddr)]};
			else if (busAddr == `EGU_OFS_IRQ_EN || busAddr == `EGU_OFS_IRQ_SET
				|| busAddr == `EGU_OFS_IRQ_CLR)
				rdata_next = {{(32-NUM_TASKS){1'b0}}, irqEn_reg};
		end
	end

	always_ff @(posedge core_clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			flag_reg    <= '0;
			irqEn_reg   <= '0;
			busRdata    <= 32'h00000000;
			chanPublish <= '0;
			irq         <= 1'b0;
			for (int n = 0; n < NUM_TASKS; n++) begin
				sub_reg[n] <= '0;
				pub_reg[n] <= '0;
			end
		end else begin
			flag_reg    <= flag_next;
			irqEn_reg   <= irqEn_next;
			busRdata    <= rdata_next;
			chanPublish <= publish_next;
			irq         <= irq_next;
			for (int n = 0; n < NUM_TASKS; n++) begin
				sub_reg[n] <= sub_next[n];
				pub_reg[n] <= pub_next[n];
			end
		end
	end

	// Instance aliases are computed here as internal signals; no port carries them out of this block.
	logic [31:0] secBase;
	logic [31:0] nsecBase;
	assign secBase  = SEC_ADDR;
	assign nsecBase = NSEC_ADDR;

	sequence S_SW_TRIG0;
		busWrite && busAddr == `EGU_OFS_TRIGGER && busWdata[0];
	endsequence

	AST_SW_TRIG_SETS_FLAG: assert property (@(posedge core_clk) disable iff (!rstSyncN)
		S_SW_TRIG0 |=> flag_reg[0])
		else $error("Trigger write did not set flag 0.");

	AST_ONLY_MATCHING_FLAG: assert property (@(posedge core_clk) disable iff (!rstSyncN)
		(!busWrite && fireTask == '0) |=> flag_reg == $past(flag_reg))
		else $error("Flag changed without a trigger or write.");

	AST_SUB_TRIGGERS: assert property (@(posedge core_clk) disable iff (!rstSyncN)
		(sub_reg[1].enable && chanFire[sub_reg[1].channel_index]) |=> flag_reg[1])
		else $error("Subscribed channel did not set flag 1.");

	AST_SUB_DISABLED: assert property (@(posedge core_clk) disable iff (!rstSyncN)
		(!sub_reg[2].enable && !busWrite && !flag_reg[2]) |=> !flag_reg[2])
		else $error("Disabled subscription set flag 2.");

	AST_PUBLISH: assert property (@(posedge core_clk) disable iff (!rstSyncN)
		(pub_reg[0].enable && fireTask[0]) |=> chanPublish[$past(pub_reg[0].channel_index)])
		else $error("Event 0 was not published.");

	AST_NO_PUBLISH: assert property (@(posedge core_clk) disable iff (!rstSyncN)
		(fireTask == '0) |=> chanPublish == '0)
		else $error("Publish without event.");

	AST_IRQ_LATENCY: assert property (@(posedge core_clk) disable iff (!rstSyncN)
		$rose(flag_reg[3]) && irqEn_reg[3] |-> irq)
		else $error("Interrupt late after enabled flag.");

	AST_IRQ_EQUATION: assert property (@(posedge core_clk) disable iff (!rstSyncN)
		irq == |(flag_reg & irqEn_reg))
		else $error("Interrupt does not match flags and enables.");

	AST_SET_ENABLE: assert property (@(posedge core_clk) disable iff (!rstSyncN)
		(busWrite && busAddr == `EGU_OFS_IRQ_SET) |=> (irqEn_reg & $past(busWdata[15:0])) ==
			$past(busWdata[15:0]))
		else $error("Set-enable write failed.");

	AST_CLR_ENABLE: assert property (@(posedge core_clk) disable iff (!rstSyncN)
		(busWrite && busAddr == `EGU_OFS_IRQ_CLR) |=> (irqEn_reg & $past(busWdata[15:0])) == '0)
		else $error("Clear-enable write failed.");

	// Read data stand for one cycle after the strobe and are zero otherwise.
	sequence S_READ_IDLE;
		!busRead;
	endsequence

	AST_RDATA_IDLE: assert property (@(posedge core_clk) disable iff (!rstSyncN)
		S_READ_IDLE |=> busRdata == 32'h00000000)
		else $error("Read data not zero outside a read.");

	AST_UNMAPPED_READ: assert property (@(posedge core_clk) disable iff (!rstSyncN)
		(busRead && busAddr == 12'h400) |=> busRdata == 32'h00000000)
		else $error("Unmapped read returned data.");

	AST_TRIG_READ_ZERO: assert property (@(posedge core_clk) disable iff (!rstSyncN)
		(busRead && busAddr == `EGU_OFS_TRIGGER) |=> busRdata == 32'h00000000)
		else $error("Trigger word read returned data.");

	AST_FLAG_READ: assert property (@(posedge core_clk) disable iff (!rstSyncN)
		(busRead && busAddr == `EGU_OFS_FLAG) |=> busRdata == {31'h00000000, $past(flag_reg[0])})
		else $error("Flag 0 read returned a wrong value.");

	AST_FLAG_HOLD_READ: assert property (@(posedge core_clk) disable iff (!rstSyncN)
		(busRead && !busWrite && busAddr == `EGU_OFS_FLAG && flag_reg[0]) |=> flag_reg[0])
		else $error("Reading flag 0 cleared it.");

	AST_EN_READ: assert property (@(posedge core_clk) disable iff (!rstSyncN)
		(busRead && busAddr == `EGU_OFS_IRQ_SET) |=> busRdata == 32'($past(irqEn_reg)))
		else $error("Set-enable read did not return the enables.");

	AST_SUB_READ: assert property (@(posedge core_clk) disable iff (!rstSyncN)
		(busRead && busAddr == `EGU_OFS_SUBSCRIBE) |=> busRdata == cfgWord($past(sub_reg[0])))
		else $error("Subscribe word 0 read returned a wrong value.");

	AST_PUB_READ: assert property (@(posedge core_clk) disable iff (!rstSyncN)
		(busRead && busAddr == `EGU_OFS_PUBLISH) |=> busRdata == cfgWord($past(pub_reg[0])))
		else $error("Publish word 0 read returned a wrong value.");

	// Configuration writes land on the edge that takes them.
	sequence S_SUB_WRITE0;
		busWrite && busAddr == `EGU_OFS_SUBSCRIBE;
	endsequence

	AST_SUB_WRITE: assert property (@(posedge core_clk) disable iff (!rstSyncN)
		S_SUB_WRITE0 |=> sub_reg[0] == {$past(busWdata[`EGU_EN_BIT]), $past(busWdata[7:0])})
		else $error("Subscribe word 0 write did not land.");

	AST_PUB_WRITE: assert property (@(posedge core_clk) disable iff (!rstSyncN)
		(busWrite && busAddr == `EGU_OFS_PUBLISH)
		|=> pub_reg[0] == {$past(busWdata[`EGU_EN_BIT]), $past(busWdata[7:0])})
		else $error("Publish word 0 write did not land.");

	AST_EN_LOAD: assert property (@(posedge core_clk) disable iff (!rstSyncN)
		(busWrite && busAddr == `EGU_OFS_IRQ_EN) |=> irqEn_reg == $past(busWdata[NUM_TASKS-1:0]))
		else $error("Enable write did not load the enables.");

	AST_SET_EXACT: assert property (@(posedge core_clk) disable iff (!rstSyncN)
		(busWrite && busAddr == `EGU_OFS_IRQ_SET)
		|=> irqEn_reg == ($past(irqEn_reg) | $past(busWdata[NUM_TASKS-1:0])))
		else $error("Set-enable write changed other enables.");

	AST_CLR_EXACT: assert property (@(posedge core_clk) disable iff (!rstSyncN)
		(busWrite && busAddr == `EGU_OFS_IRQ_CLR)
		|=> irqEn_reg == ($past(irqEn_reg) & ~$past(busWdata[NUM_TASKS-1:0])))
		else $error("Clear-enable write changed other enables.");

	// Event flags move only through their own task or their own word.
	AST_ZERO_TRIG_NO_FLAG: assert property (@(posedge core_clk) disable iff (!rstSyncN)
		(busWrite && busAddr == `EGU_OFS_TRIGGER && !busWdata[0] && !fireTask[0] && !flag_reg[0])
		|=> !flag_reg[0])
		else $error("Trigger write of zero set flag 0.");

	AST_FLAG_CLEAR: assert property (@(posedge core_clk) disable iff (!rstSyncN)
		(busWrite && busAddr == `EGU_OFS_FLAG && !busWdata[0] && !fireTask[0]) |=> !flag_reg[0])
		else $error("Writing zero did not clear flag 0.");

	AST_TRIG_ONLY_N: assert property (@(posedge core_clk) disable iff (!rstSyncN)
		S_SW_TRIG0 ##0 (fireTask[NUM_TASKS-1:1] == '0)
		|=> flag_reg[NUM_TASKS-1:1] == $past(flag_reg[NUM_TASKS-1:1]))
		else $error("Trigger 0 touched another flag.");

	AST_PUB_DISABLED: assert property (@(posedge core_clk) disable iff (!rstSyncN)
		(!pub_reg[0].enable && fireTask == NUM_TASKS'(1)) |=> chanPublish == '0)
		else $error("Disabled event 0 was published.");

	AST_IRQ_HOLD: assert property (@(posedge core_clk) disable iff (!rstSyncN)
		(irq && !busWrite) |=> irq)
		else $error("Interrupt dropped without a software write.");

	AST_IRQ_FALL: assert property (@(posedge core_clk) disable iff (!rstSyncN)
		$fell(irq) |-> $past(busWrite))
		else $error("Interrupt fell without a software write.");

endmodule

// >>> bench/egu_chan_model.sv
// Interconnect channel model that pulses channels into the event generator.
`timescale 1ns/100ps
module egu_chan_model (
	input  wire logic         core_clk,      // Peripheral clock.
	input  wire logic         fireGo,        // Request one channel pulse.
	input  wire logic [7:0]   fireCh,        // Channel to pulse.
	output logic      [255:0] chanFire = '0  // Channel pulses to the block.
);
	// Each request becomes exactly one single-cycle pulse on one channel.
	always @(posedge core_clk) begin
		chanFire <= fireGo ? (256'h1 << fireCh) : 256'h0;
	end
endmodule

// >>> bench/test_egu_event_generator.sv
// Self-checking testbench of the event generator.
`timescale 1ns/100ps
`include "egu_map.svh"
module test_egu_event_generator import egu_pkg::*;;
	logic         core_clk = 0;
	logic         rstn = 0;
	logic         busWrite = 0;
	logic         busRead = 0;
	logic         fireGo = 0;
	logic [7:0]   fireCh = '0;
	logic [11:0]  busAddr = '0;
	logic [31:0]  busWdata = '0;
	logic [31:0]  busRdata;
	logic [31:0]  v;
	logic [255:0] chanFire;
	logic [255:0] chanPublish;
	logic         irq;
	logic [15:0]  en;
	logic [15:0]  flags = '0;
	logic [7:0]   c;
	int           n;
	int           seed;
	int           n_mismatch = 0;
	int           n_tests = 0;

	always #2 core_clk = ~core_clk;

	egu_event_generator DUT (.core_clk(core_clk), .rstn(rstn), .busAddr(busAddr),
		.busWdata(busWdata), .busWrite(busWrite), .busRead(busRead), .busRdata(busRdata),
		.chanFire(chanFire), .chanPublish(chanPublish), .irq(irq));
	egu_chan_model partner (.core_clk(core_clk), .fireGo(fireGo), .fireCh(fireCh),
		.chanFire(chanFire));

	function automatic logic [11:0] at(input logic [11:0] base, input int i);
		return base + 12'(i * 4);
	endfunction
	function automatic logic [31:0] expIrq(input logic [15:0] f, input logic [15:0] e);
		return {31'h0, |(f & e)};
	endfunction

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge core_clk);
		busAddr <= a;
		busWdata <= d;
		busWrite <= 1'b1;
		@(posedge core_clk);
		busWrite <= 1'b0;
	endtask
	task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
		@(posedge core_clk);
		busAddr <= a;
		busRead <= 1'b1;
		@(posedge core_clk);
		busRead <= 1'b0;
		#1 chk(busRdata, exp);
	endtask
	task automatic stop_test;
		$display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	initial begin
		#80000;
		n_mismatch++;
		stop_test;
	end

	initial begin
		seed = 32'h0fb4;
		repeat (12) @(posedge core_clk);
		rstn <= 1'b1;
		repeat (3) @(posedge core_clk);
		rdc(at(`EGU_OFS_SUBSCRIBE, 5), 32'h0);
		rdc(`EGU_OFS_IRQ_EN, 32'h0);
		rdc(12'h400, 32'h0);
		rdc(`EGU_OFS_TRIGGER, 32'h0);
		rdc(`EGU_OFS_PUBLISH, 32'h0);
		$display("test reset done");
		for (int i = 0; i < 4; i++) begin
			v = $random(seed);
			wr(`EGU_OFS_IRQ_EN, v);
			en = v[15:0];
			rdc(`EGU_OFS_IRQ_SET, {16'h0, en});
			v = $random(seed);
			wr(`EGU_OFS_IRQ_SET, v);
			en = en | v[15:0];
			rdc(`EGU_OFS_IRQ_CLR, {16'h0, en});
			v = $random(seed);
			wr(`EGU_OFS_IRQ_CLR, v);
			en = en & ~v[15:0];
			rdc(`EGU_OFS_IRQ_EN, {16'h0, en});
		end
		$display("test enables done");
		en = 16'h00FF;
		wr(`EGU_OFS_IRQ_EN, {16'h0, en});
		for (int i = 0; i < 8; i++) begin
			n = (i == 0) ? 0 : (i == 1) ? 3 : ($random(seed) & 15);
			// The first write leaves bit 0 clear and must not trigger.
			wr(at(`EGU_OFS_TRIGGER, n), (i == 0) ? 32'hFFFFFFFE : 32'h1);
			flags[n] = flags[n] | (i != 0);
			#1 chk(irq, expIrq(flags, en));
			rdc(at(`EGU_OFS_FLAG, n), {31'h0, flags[n]});
			rdc(at(`EGU_OFS_FLAG, n ^ 1), {31'h0, flags[n ^ 1]});
		end
		for (int i = 0; i < 16; i++) wr(at(`EGU_OFS_FLAG, i), 32'h0);
		flags = '0;
		#1 chk(irq, 32'h0);
		$display("test triggers done");
		for (int i = 0; i < 6; i++) begin
			n = (i < 2) ? i : ($random(seed) & 15);
			c = 8'($random(seed));
			wr(at(`EGU_OFS_SUBSCRIBE, n), {i[0], 23'h0, c});
			rdc(at(`EGU_OFS_SUBSCRIBE, n), {i[0], 23'h0, c});
			@(posedge core_clk);
			fireGo <= 1'b1;
			fireCh <= c;
			@(posedge core_clk);
			fireGo <= 1'b0;
			@(posedge core_clk);
			rdc(at(`EGU_OFS_FLAG, n), {31'h0, i[0]});
			wr(at(`EGU_OFS_FLAG, n), 32'h0);
			wr(at(`EGU_OFS_SUBSCRIBE, n), 32'h0);
		end
		$display("test subscribe done");
		for (int i = 0; i < 6; i++) begin
			n = (i < 2) ? 0 : ($random(seed) & 15);
			c = 8'($random(seed));
			wr(at(`EGU_OFS_PUBLISH, n), {i[0], 23'h0, c});
			wr(at(`EGU_OFS_TRIGGER, n), 32'h1);
			#1 chk(32'($countones(chanPublish)), {31'h0, i[0]});
			chk({31'h0, chanPublish[c]}, {31'h0, i[0]});
			@(posedge core_clk);
			#1 chk(32'($countones(chanPublish)), 32'h0);
		end
		$display("test publish done");
		stop_test;
	end
endmodule
